// ===== conv_bus_if.sv
// Strobe, completion and tri-state data pins between host and converter
`timescale 1ns/1ps
`default_nettype none
interface conv_bus_if;
   logic csN;
   logic wrN;
   logic rdN;
   logic convDoneN;
   logic [sar_pkg::DATA_W-1:0] dataOut;
   logic dataOeN;
   logic [sar_pkg::DATA_W-1:0] dataBus;

   // Undriven bus floats to all ones, as with pull-ups
   assign dataBus = dataOeN ? {sar_pkg::DATA_W{1'b1}} : dataOut;

   modport device (
      input csN,
      input wrN,
      input rdN,
      output convDoneN,
      output dataOut,
      output dataOeN
   );

   modport host (
      output csN,
      output wrN,
      output rdN,
      input convDoneN,
      input dataBus
   );
endinterface
`default_nettype wire

// ===== sar_adc_bus_control.sv
// Successive approximation control with strobe bus and result latch
//
// Function
// - Decide all bits, then latch result at once
// - Start only by strobe pulse with select low
// - Start-or-select fall resets approximation, done high
// - Both strobes low holds converter in reset
// - Conversion starts up to eight periods later
// - Completion pulls done line low
// - Read with select clears done, drives data
// - New start aborts running conversion
// - Select, start and read are active low
// - Without processor, select tied low, pulse start
// - Read held low shows latest result
// - Free-running with done fed back to start
`timescale 1ns/1ps
`default_nettype none
module sar_adc_bus_control (
   input wire logic clk,
   input wire logic rst,
   conv_bus_if.device bus,
   input wire logic [sar_pkg::DATA_W-1:0] sampleIn,
   output logic converting
);
   import sar_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   dev_state_t state_reg;
   dev_state_t state_next;
   logic [DIV_W-1:0] divCnt_reg;
   logic [2:0] phase_reg;
   logic [5:0] acqCnt_reg;
   logic [DATA_W-1:0] approx_register;
   logic [DATA_W-1:0] shift_reg;
   logic [DATA_W-1:0] sampleHold_reg;
   logic [DATA_W-1:0] decided;
   logic [DATA_W-1:0] result_reg;
   logic doneN_reg;
   logic oeN_reg;
   logic converting_reg;
   logic startLowPrev_reg;
   logic tick;
   logic startLow;
   logic startFall;
   logic readAccess;
   logic acqEnd;
   logic lastBit;

   assign bus.convDoneN = doneN_reg;
   assign bus.dataOut = result_reg;
   assign bus.dataOeN = oeN_reg;
   assign converting = converting_reg;

   // ----------------------------------------------------------------
   // Converter clock enable
   // ----------------------------------------------------------------
   // Converter rate is a one-cycle enable, not a derived clock
   assign tick = (divCnt_reg == DIV_LAST);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         divCnt_reg <= '0;
      else if (tick)
         divCnt_reg <= '0;
      else
         divCnt_reg <= divCnt_reg + 1'b1;
   end

   // Free-running phase sets where the start lands after release
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         phase_reg <= '0;
      else if (tick)
         phase_reg <= phase_reg + 1'b1;
   end

   // ----------------------------------------------------------------
   // Strobe decode
   // ----------------------------------------------------------------
   // Select and start only act together, both low
   assign startLow = !bus.csN && !bus.wrN;
   assign startFall = startLow && !startLowPrev_reg;
   assign readAccess = !bus.csN && !bus.rdN;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         startLowPrev_reg <= 1'b0;
      else
         startLowPrev_reg <= startLow;
   end

   // ----------------------------------------------------------------
   // Sequence control
   // ----------------------------------------------------------------
   assign acqEnd = tick && (acqCnt_reg == ACQ_LAST);
   assign lastBit = tick && (shift_reg == SHIFT_LSB);

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         D_IDLE:
         begin
            if (startLow)
               state_next = D_HOLD;
         end
         D_HOLD:
         begin
            if (!startLow)
               state_next = D_WAIT;
         end
         D_WAIT:
         begin
            if (tick && phase_reg == PHASE_LAST)
               state_next = D_ACQ;
         end
         D_ACQ:
         begin
            if (acqEnd)
               state_next = D_BITS;
         end
         D_BITS:
         begin
            if (lastBit)
               state_next = D_IDLE;
         end
      endcase
      // A start in any state restarts the sequence from reset
      if (startLow)
         state_next = D_HOLD;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_reg <= D_IDLE;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         acqCnt_reg <= '0;
      else if (state_reg != D_ACQ)
         acqCnt_reg <= '0;
      else if (tick)
         acqCnt_reg <= acqCnt_reg + 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         converting_reg <= 1'b0;
      else
         converting_reg <= (state_next != D_IDLE) && (state_next != D_HOLD);
   end

   // ----------------------------------------------------------------
   // Approximation
   // ----------------------------------------------------------------
   // Comparator is strobed at the period end, after input settles
   assign decided = (approx_register > sampleHold_reg) ?
                    (approx_register & ~shift_reg) : approx_register;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         approx_register <= APPROX_INIT;
         shift_reg <= SHIFT_CLEAR;
      end
      else if (startLow)
      begin
         approx_register <= APPROX_INIT;
         shift_reg <= SHIFT_CLEAR;
      end
      else if (state_reg == D_ACQ && acqEnd)
         shift_reg <= APPROX_INIT;
      else if (state_reg == D_BITS && tick)
      begin
         approx_register <= decided | (shift_reg >> 1);
         shift_reg <= shift_reg >> 1;
      end
   end

   // Sample is frozen once, so every bit is judged on the same value
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sampleHold_reg <= '0;
      else if (state_reg == D_ACQ && acqEnd)
         sampleHold_reg <= sampleIn;
   end

   // ----------------------------------------------------------------
   // Result latch and pins
   // ----------------------------------------------------------------
   // An aborted conversion leaves the previous result in place
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         result_reg <= RESULT_RESET;
      else if (state_reg == D_BITS && lastBit)
         result_reg <= decided;
   end

   // Completion beats a read or start in the same cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         doneN_reg <= 1'b1;
      else if (state_reg == D_BITS && lastBit)
         doneN_reg <= 1'b0;
      else if (startFall)
         doneN_reg <= 1'b1;
      else if (readAccess)
         doneN_reg <= 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         oeN_reg <= 1'b1;
      else
         oeN_reg <= !readAccess;
   end
endmodule
`default_nettype wire

// ===== sar_bus_chk.sv
// Checker for the strobe, completion and data pins of the converter bus
`timescale 1ns/1ps
`default_nettype none
module sar_bus_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic wrN,
   input wire logic rdN,
   input wire logic convDoneN,
   input wire logic [sar_pkg::DATA_W-1:0] dataOut,
   input wire logic dataOeN,
   input wire logic [sar_pkg::DATA_W-1:0] dataBus
);
   import sar_pkg::*;
   int relCnt_reg;
   logic startLow;

   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   assign startLow = !csN && !wrN;

   // Cycles since the start condition was released; saturates
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         relCnt_reg <= 0;
      else if (startLow)
         relCnt_reg <= 0;
      else if (relCnt_reg < 4000)
         relCnt_reg <= relCnt_reg + 1;
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_read;
      !csN && !rdN;
   endsequence

   sequence s_hold;
      (!csN && !wrN) [*1];
   endsequence

   a_oe_on_read: assert property (s_read |=> !dataOeN)
      else $error("data bus not driven during read");
   a_oe_off_idle: assert property ((csN || rdN) |=> dataOeN)
      else $error("data bus driven without read");
   a_read_clears_done: assert property
      ((!csN && $fell(rdN) && !convDoneN) |=> convDoneN)
      else $error("read did not clear completion");
   a_start_sets_done: assert property ($rose(startLow) |=> convDoneN)
      else $error("start did not raise completion");
   a_hold_in_reset: assert property
      (s_hold |=> convDoneN && $stable(dataOut))
      else $error("converter left reset while start held");
   a_conv_window: assert property
      ($fell(convDoneN) |-> relCnt_reg >= 1599 && relCnt_reg <= 1801)
      else $error("conversion time out of window");
   a_latch_on_done: assert property
      (!$fell(convDoneN) |-> $stable(dataOut))
      else $error("result latch changed without completion");
   a_done_stands: assert property
      ((!convDoneN && (csN || (rdN && wrN))) |=> !convDoneN)
      else $error("completion released without read or start");
endmodule
`default_nettype wire

// ===== sar_host_control.sv
// Host end: issues start and read strobes and buffers results
`timescale 1ns/1ps
`default_nettype none
module sar_host_control (
   input wire logic clk,
   input wire logic rst,
   conv_bus_if.host bus,
   input wire logic convReq,
   input wire logic freeRun,
   output logic outValid,
   output logic [sar_pkg::DATA_W-1:0] outData,
   input wire logic outReady,
   output logic busy
);
   import sar_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   host_state_t state_reg;
   logic [1:0] cnt_reg;
   logic csN_reg;
   logic wrN_reg;
   logic rdN_reg;
   logic busy_reg;
   logic pushValid_reg;
   logic [DATA_W-1:0] pushData_reg;
   logic freeWait_reg;
   logic bufReady;
   logic freeTake;

   assign bus.csN = csN_reg;
   assign bus.wrN = wrN_reg;
   assign bus.rdN = rdN_reg;
   assign busy = busy_reg;

   // Buffer full holds back reads, so no finished word is dropped
   two_entry_buffer #(
      .WIDTH(DATA_W),
      .DEPTH(BUF_DEPTH)
   ) resultBuf (
      .clk(clk),
      .rst(rst),
      .inValid(pushValid_reg),
      .inData(pushData_reg),
      .inReady(bufReady),
      .outValid(outValid),
      .outData(outData),
      .outReady(outReady)
   );

   // Free run: the held-low read clears done after one cycle, so a
   // completion met with a full buffer is remembered until room appears
   assign freeTake = freeRun && state_reg == H_IDLE
                     && (!bus.convDoneN || freeWait_reg)
                     && bufReady && !pushValid_reg;

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= H_IDLE;
         cnt_reg <= '0;
      end
      else
      begin
         cnt_reg <= cnt_reg + 1'b1;
         unique case (state_reg)
            H_IDLE:
            begin
               cnt_reg <= '0;
               if (convReq && !freeRun)
                  state_reg <= H_START;
            end
            H_START:
            begin
               if (cnt_reg == START_LAST)
                  state_reg <= H_WAIT;
            end
            H_WAIT:
            begin
               cnt_reg <= '0;
               if (!bus.convDoneN && bufReady && !pushValid_reg)
                  state_reg <= H_READ;
            end
            H_READ:
            begin
               if (cnt_reg == ACC_LAST)
                  state_reg <= H_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Strobes and capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         csN_reg <= 1'b1;
         wrN_reg <= 1'b1;
         rdN_reg <= 1'b1;
         busy_reg <= 1'b0;
         pushValid_reg <= 1'b0;
         pushData_reg <= '0;
         freeWait_reg <= 1'b0;
      end
      else
      begin
         pushValid_reg <= 1'b0;
         busy_reg <= (state_reg != H_IDLE) || freeRun;
         if (!freeRun || freeTake)
            freeWait_reg <= 1'b0;
         else if (state_reg == H_IDLE && !bus.convDoneN)
            freeWait_reg <= 1'b1;
         if (state_reg == H_IDLE && freeRun)
         begin
            csN_reg <= 1'b0;
            rdN_reg <= 1'b0;
            // Done fed back as start once the word is taken; a request
            // kicks the first one
            wrN_reg <= !(convReq || freeTake);
            if (freeTake)
            begin
               pushValid_reg <= 1'b1;
               pushData_reg <= bus.dataBus;
            end
         end
         else if (state_reg == H_IDLE)
         begin
            csN_reg <= !(convReq);
            wrN_reg <= !(convReq);
            rdN_reg <= 1'b1;
         end
         else if (state_reg == H_START && cnt_reg == START_LAST)
         begin
            wrN_reg <= 1'b1;
            csN_reg <= 1'b1;
         end
         else if (state_reg == H_WAIT && !bus.convDoneN && bufReady
                  && !pushValid_reg)
         begin
            csN_reg <= 1'b0;
            rdN_reg <= 1'b0;
         end
         else if (state_reg == H_READ && cnt_reg == ACC_LAST)
         begin
            pushValid_reg <= 1'b1;
            pushData_reg <= bus.dataBus;
            csN_reg <= 1'b1;
            rdN_reg <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sar_pkg.sv
// Shared constants and state types of the converter control and its host
package sar_pkg;

   // ----------------------------------------------------------------
   // Clocking
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int CONV_CLK_HZ = 1_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int DIV_CYC = CLK_HZ / CONV_CLK_HZ;
   localparam int DIV_W = 5;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYC - 1);

   // ----------------------------------------------------------------
   // Conversion sequence, counted in converter clock periods
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int START_DELAY_PERIODS = 8;
   localparam logic [2:0] PHASE_LAST = 3'(START_DELAY_PERIODS - 1);
   localparam int ACQ_PERIODS = 56;
   localparam logic [5:0] ACQ_LAST = 6'(ACQ_PERIODS - 1);
   localparam logic [DATA_W-1:0] APPROX_INIT = 8'h80;
   localparam logic [DATA_W-1:0] SHIFT_CLEAR = 8'h00;
   localparam logic [DATA_W-1:0] SHIFT_LSB = 8'h01;
   localparam logic [DATA_W-1:0] RESULT_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Host strobe timing
   // ----------------------------------------------------------------
   localparam int START_PULSE_NS = 30;
   localparam int ACCESS_NS = 100;
   localparam int START_CYC = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] START_LAST = 2'(START_CYC - 1);
   localparam logic [1:0] ACC_LAST = 2'(ACC_CYC - 1);
   localparam int BUF_DEPTH = 2;

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {D_IDLE, D_HOLD, D_WAIT, D_ACQ, D_BITS} dev_state_t;
   typedef enum logic [1:0] {H_IDLE, H_START, H_WAIT, H_READ} host_state_t;

endpackage

// ===== testbench.sv
// Bench: host and converter face to face, plus a converter driven bare
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sar_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [DATA_W-1:0] sampleIn = 8'h00;
   logic [DATA_W-1:0] sampleB = 8'h00;
   logic [DATA_W-1:0] tailVal = 8'hxx;
   logic [DATA_W-1:0] outData;
   logic [DATA_W-1:0] v;
   logic [DATA_W-1:0] expQ[$];
   logic convReq = 1'b0;
   logic freeRun = 1'b0;
   logic outReady = 1'b0;
   logic stall = 1'b1;
   logic outValid;
   logic busy;
   logic converting;
   logic convB;
   int error_cnt = 0;
   int n_compared = 0;
   int cycles = 0;
   int seed = 32'h638c;
   int n;

   conv_bus_if u_conv_bus_if ();
   conv_bus_if u_conv_bus_if_b ();
   sar_adc_bus_control u_sar_adc_bus_control (.clk(clk), .rst(rst),
      .bus(u_conv_bus_if), .sampleIn(sampleIn), .converting(converting));
   sar_adc_bus_control u_sar_adc_bus_control_b (.clk(clk), .rst(rst),
      .bus(u_conv_bus_if_b), .sampleIn(sampleB), .converting(convB));
   sar_host_control u_sar_host_control (.clk(clk), .rst(rst),
      .bus(u_conv_bus_if), .convReq(convReq), .freeRun(freeRun),
      .outValid(outValid), .outData(outData), .outReady(outReady),
      .busy(busy));
   sar_bus_chk u_sar_bus_chk (.clk(clk), .rst(rst),
      .csN(u_conv_bus_if.csN), .wrN(u_conv_bus_if.wrN),
      .rdN(u_conv_bus_if.rdN), .convDoneN(u_conv_bus_if.convDoneN),
      .dataOut(u_conv_bus_if.dataOut), .dataOeN(u_conv_bus_if.dataOeN),
      .dataBus(u_conv_bus_if.dataBus));

   // ----------------------------------------------------------------
   // Clock, drain stalls, timeout and result watcher
   // ----------------------------------------------------------------
   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   always @(posedge clk)
      outReady <= !stall && ($random(seed) % 4 != 0);

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   // An empty queue compares against tailVal, unknown unless free running
   always @(posedge clk)
      if (!rst && outValid === 1'b1 && outReady === 1'b1)
         cmp8(outData, expQ.size() > 0 ? expQ.pop_front() : tailVal);

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic cmp8(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic pins(input logic c, input logic w, input logic r);
      @(posedge clk);
      u_conv_bus_if_b.csN <= c;
      u_conv_bus_if_b.wrN <= w;
      u_conv_bus_if_b.rdN <= r;
   endtask

   task automatic wait_done(output int k);
      for (k = 0; k < 2500 && u_conv_bus_if_b.convDoneN !== 1'b0; k++)
         @(negedge clk);
      cmp1(k < 2500, 1'b1);
   endtask

   // Input held until the host is idle, so acquisition sees a stable code
   task automatic request(input logic [DATA_W-1:0] d);
      for (int k = 0; k < 9000 && busy !== 1'b0; k++)
         @(negedge clk);
      @(posedge clk);
      sampleIn <= d;
      convReq <= 1'b1;
      expQ.push_back(d);
      @(posedge clk);
      convReq <= 1'b0;
      // Busy rises a cycle after the host leaves idle
      repeat (2) @(negedge clk);
   endtask

   task automatic drain();
      for (int k = 0; k < 9000 && expQ.size() > 0; k++)
         @(negedge clk);
      cmp1(expQ.size() == 0, 1'b1);
   endtask

   task automatic endtest(input string name);
      $display("test %s finished, %0d mismatches so far", name, error_cnt);
   endtask

   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      u_conv_bus_if_b.csN = 1'b1;
      u_conv_bus_if_b.wrN = 1'b1;
      u_conv_bus_if_b.rdN = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      stall <= 1'b0;
      request(8'h00);
      request(8'hff);
      for (int k = 0; k < 2; k++)
         request(8'($random(seed)));
      drain();
      endtest("single");
      stall <= 1'b1;
      for (int k = 0; k < 3; k++)
         request(8'($random(seed)));
      repeat (2500) @(negedge clk);
      cmp1(busy, 1'b1);
      cmp1(u_conv_bus_if.convDoneN, 1'b0);
      cmp1(converting, 1'b0);
      stall <= 1'b0;
      drain();
      endtest("buffer");
      v = 8'($random(seed));
      sampleIn <= v;
      tailVal <= v;
      repeat (4) expQ.push_back(v);
      freeRun <= 1'b1;
      @(posedge clk);
      convReq <= 1'b1;
      @(posedge clk);
      convReq <= 1'b0;
      drain();
      freeRun <= 1'b0;
      repeat (4000) @(negedge clk);
      tailVal <= 8'hxx;
      endtest("free run");
      pins(1'b1, 1'b0, 1'b1);
      pins(1'b1, 1'b1, 1'b1);
      repeat (10) @(negedge clk);
      cmp1(convB, 1'b0);
      sampleB <= 8'($random(seed));
      pins(1'b0, 1'b0, 1'b1);
      pins(1'b0, 1'b1, 1'b1);
      repeat (800) @(negedge clk);
      cmp1(convB, 1'b1);
      v = 8'($random(seed));
      sampleB <= v;
      pins(1'b0, 1'b0, 1'b1);
      pins(1'b0, 1'b1, 1'b1);
      wait_done(n);
      cmp1(n >= 1590 && n <= 1810, 1'b1);
      pins(1'b0, 1'b0, 1'b1);
      pins(1'b0, 1'b0, 1'b0);
      repeat (3) @(negedge clk);
      cmp1(u_conv_bus_if_b.convDoneN, 1'b1);
      repeat (2500) @(negedge clk);
      cmp1(convB, 1'b0);
      cmp8(u_conv_bus_if_b.dataBus, v);
      v = 8'($random(seed));
      sampleB <= v;
      pins(1'b0, 1'b1, 1'b0);
      wait_done(n);
      repeat (3) @(negedge clk);
      cmp8(u_conv_bus_if_b.dataBus, v);
      cmp1(u_conv_bus_if_b.convDoneN, 1'b1);
      pins(1'b1, 1'b1, 1'b0);
      repeat (3) @(negedge clk);
      cmp8(u_conv_bus_if_b.dataBus, 8'hff);
      endtest("bare converter");
      complete_run();
   end
endmodule
`default_nettype wire

// ===== two_entry_buffer.sv
// Small shifting buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer
   import sar_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = BUF_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [DEPTH-1:0] vld_reg;
   logic [DEPTH-1:0] vld_next;
   logic placed;

   // Head entry is always slot 0, so the outputs are flip-flops
   assign outValid = vld_reg[0];
   assign outData = mem_reg[0];
   assign inReady = ~vld_reg[DEPTH-1];

   always_comb
   begin
      placed = 1'b0;
      for (int i = 0; i < DEPTH; i++)
      begin
         mem_next[i] = mem_reg[i];
         vld_next[i] = vld_reg[i];
      end
      if (outValid && outReady)
      begin
         for (int i = 0; i < DEPTH - 1; i++)
         begin
            mem_next[i] = mem_reg[i+1];
            vld_next[i] = vld_reg[i+1];
         end
         vld_next[DEPTH-1] = 1'b0;
      end
      for (int i = 0; i < DEPTH; i++)
      begin
         if (inValid && inReady && !placed && !vld_next[i])
         begin
            mem_next[i] = inData;
            vld_next[i] = 1'b1;
            placed = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         vld_reg <= '0;
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= '0;
      end
      else
      begin
         vld_reg <= vld_next;
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= mem_next[i];
      end
   end
endmodule
`default_nettype wire
